// >>> pkg/gcq_pkg.sv
// shared constants and types for the graphics command queue controller
`default_nettype none
package gcq_pkg;
   localparam logic [7:0]  CMD_COPY   = 8'h0C;  // rect_memory_copy
   localparam logic [7:0]  CMD_STORE  = 8'h0D;  // physical_block_store
   localparam logic [7:0]  CMD_LOAD   = 8'h0E;  // physical_block_load
   localparam logic [7:0]  CMD_POLY   = 8'h0F;  // draw_polyline
   localparam logic [7:0]  CMD_NOP    = 8'hFF;  // no_operation_cmd
   localparam int          MEM_AW     = 24;     // fitted video memory byte address width
   localparam logic [23:0] ADDR_STEP  = 24'h000004;
   localparam logic [31:0] LAYER_MASK = 32'hC000C000; // point bits 31,30,15,14
   localparam int          X_LSB      = 16;
   localparam int          CW         = 14;     // coordinate width
   localparam int          DEPTH_W    = 3;
   localparam logic [2:0]  BPP1       = 3'h0;
   localparam logic [2:0]  BPP2       = 3'h1;
   localparam logic [2:0]  BPP4       = 3'h2;
   localparam logic [2:0]  BPP8       = 3'h3;
   localparam logic [2:0]  BPP16      = 3'h4;
   localparam logic [2:0]  BPP24      = 3'h5;
   localparam logic [7:0]  RST_CODE   = 8'h00;
   localparam logic [31:0] RST_WORD   = 32'h00000000;
   localparam logic [1:0]  STEP0      = 2'h0;
   localparam logic [1:0]  STEP1      = 2'h1;
   localparam logic [1:0]  STEP2      = 2'h2;
   typedef enum logic [3:0] {
      ST_IDLE  = 4'h0,
      ST_DISP  = 4'h1,
      ST_FETCH = 4'h2,
      ST_MEMW  = 4'h3,
      ST_MEMR  = 4'h4,
      ST_PUSH  = 4'h5,
      ST_COPY  = 4'h6,
      ST_LINE  = 4'h7,
      ST_NO_OPERATION_CMD  = 4'h8
   } gcq_state_t;
endpackage : gcq_pkg
`default_nettype wire

// >>> logic/gcq_ctrl.sv
// command queue and sequencer for copy, physical store/load and polyline commands
// Functional notes
// - code 0Ch copies rectangles repeatedly until the command ends
// - each copy takes source start, source end, target start words
// - source end layer bits dropped; target end derived from source size
// - differing source and target depths set sticky mismatch flag
// - code 0Dh: first word is byte address, data words to incrementing addresses
// - code 0Eh: address then exactly parameter-count words into output queue
// - code 0Fh: start point then next points, each ending and starting a line
// - layer of each next point honoured unless use_layer_register selects target_layer_select; colour fixed for the command
// - only colour bits matching target layer depth are used
// - code FFh is a single dummy cycle
// - single colours are right-aligned; depths 24,16,8,4,2,1
// - 24 bpp packed data runs across words, first pixel left-aligned
// - point words without layer have bits 31,30,15,14 ignored
// - queue holds the running command and one buffered command
// - each unit reports busy; controller sequences hand-over itself
// - input and output queue status flags are presented
// - DMA requests offered for input and output queues
// - software reset clears this controller's state
// - only address bits of the fitted memory are used
`timescale 1ns/1ps
`default_nettype none
module gcq_ctrl (
   input  wire logic        i_clk,          // system clock 200 MHz
   input  wire logic        i_rst_b,        // async reset, active low
   input  wire logic        i_sw_reset,     // software reset pulse
   input  wire logic        i_cmd_wr,       // command write strobe
   input  wire logic [7:0]  i_cmd_code,     // command code
   input  wire logic [15:0] i_cmd_param,    // command_parameter_count
   input  wire logic [23:0] i_poly_colour,  // polygon_colour
   input  wire logic [3:0]  i_target_layer, // target_layer_select
   input  wire logic        i_use_layer,    // use_layer_register
   input  wire logic [47:0] i_layer_depth,  // 3-bit depth code per layer
   input  wire logic        i_err_clr,      // clears depth_mismatch_error
   input  wire logic        i_inq_valid,    // input_queue word valid
   input  wire logic [31:0] i_inq_data,     // input_queue word
   input  wire logic        i_outq_ready,   // output_queue drain ready
   input  wire logic        i_mem_ack,      // memory access done
   input  wire logic [31:0] i_mem_rdata,    // memory read data
   input  wire logic        i_copy_ack,     // copy_unit took area
   input  wire logic        i_line_ack,     // drawing_engine took line
   output logic             o_cmd_wen,      // command_write_enable
   output logic             o_inq_ready,    // input word taken when valid
   output logic             o_outq_valid,   // output_queue word valid
   output logic [31:0]      o_outq_data,    // output_queue word
   output logic             o_mem_req,      // memory access request
   output logic             o_mem_we,       // memory write
   output logic [23:0]      o_mem_addr,     // physical byte address
   output logic [31:0]      o_mem_wdata,    // memory write data
   output logic             o_copy_req,     // copy area request
   output logic [31:0]      o_copy_src,     // source start with layer
   output logic [31:0]      o_copy_src_end, // source end, no layer
   output logic [31:0]      o_copy_tgt,     // target start with layer
   output logic [31:0]      o_copy_tgt_end, // derived target end, no layer
   output logic             o_line_req,     // line request
   output logic [31:0]      o_line_start,   // line start, no layer
   output logic [31:0]      o_line_end,     // line end, no layer
   output logic [3:0]       o_line_layer,   // line layer
   output logic [23:0]      o_line_colour,  // depth-masked colour
   output logic             o_depth_err,    // depth_mismatch_error
   output logic             o_copy_busy,    // copy_unit busy
   output logic             o_phys_busy,    // physical_access_unit busy
   output logic             o_draw_busy,    // drawing_engine busy
   output logic             o_dreq_in,      // DMA request into input queue
   output logic             o_dreq_out      // DMA request from output queue
);
   gcq_pkg::gcq_state_t state, next_state;
   logic        q0_v, q1_v, next_q0_v, next_q1_v;
   logic [7:0]  q0_code, q1_code, next_q0_code, next_q1_code;
   logic [1:0]  step, next_step;
   logic [15:0] cnt, next_cnt;
   logic [23:0] colour, next_colour;
   logic [31:0] pt_a, next_pt_a;
   logic        next_cwen, next_inq_ready, next_outq_valid, next_mem_req, next_mem_we;
   logic [31:0] next_outq_data, next_mem_wdata;
   logic [23:0] next_mem_addr;
   logic        next_copy_req, next_line_req, next_err;
   logic [31:0] next_copy_src, next_copy_src_end, next_copy_tgt, next_copy_tgt_end;
   logic [31:0] next_line_start, next_line_end;
   logic [3:0]  next_line_layer;
   logic [23:0] next_line_colour;
   logic        take, done, err_set;
   logic [gcq_pkg::CW-1:0] ex, ey;

   // layer number sits in the don't-care bit positions of a point word
   function automatic logic [3:0] lay_of(input logic [31:0] w);
      lay_of = {w[31], w[30], w[15], w[14]};
   endfunction : lay_of

   function automatic logic [2:0] depth_of(input logic [3:0] l, input logic [47:0] t);
      depth_of = t[l*gcq_pkg::DEPTH_W +: gcq_pkg::DEPTH_W];
   endfunction : depth_of

   // right-aligned colours keep only low bits
   function automatic logic [23:0] cmask(input logic [2:0] d);
      unique case (d)
         gcq_pkg::BPP1:  cmask = 24'h000001;
         gcq_pkg::BPP2:  cmask = 24'h000003;
         gcq_pkg::BPP4:  cmask = 24'h00000F;
         gcq_pkg::BPP8:  cmask = 24'h0000FF;
         gcq_pkg::BPP16: cmask = 24'h00FFFF;
         default:        cmask = 24'hFFFFFF;
      endcase
   endfunction : cmask

   // queue, sequencer and unit handshakes
   always_comb begin
      next_state = state;
      next_q0_v = q0_v;
      next_q1_v = q1_v;
      next_q0_code = q0_code;
      next_q1_code = q1_code;
      next_step = step;
      next_cnt = cnt;
      next_colour = colour;
      next_pt_a = pt_a;
      next_outq_valid = o_outq_valid;
      next_outq_data = o_outq_data;
      next_mem_req = o_mem_req;
      next_mem_we = o_mem_we;
      next_mem_addr = o_mem_addr;
      next_mem_wdata = o_mem_wdata;
      next_copy_req = o_copy_req;
      next_copy_src = o_copy_src;
      next_copy_src_end = o_copy_src_end;
      next_copy_tgt = o_copy_tgt;
      next_copy_tgt_end = o_copy_tgt_end;
      next_line_req = o_line_req;
      next_line_start = o_line_start;
      next_line_end = o_line_end;
      next_line_layer = o_line_layer;
      next_line_colour = o_line_colour;
      err_set = 1'b0;
      done = 1'b0;
      take = i_inq_valid && o_inq_ready;
      ex = i_inq_data[gcq_pkg::X_LSB +: gcq_pkg::CW]
           + o_copy_src_end[gcq_pkg::X_LSB +: gcq_pkg::CW]
           - o_copy_src[gcq_pkg::X_LSB +: gcq_pkg::CW];
      ey = i_inq_data[gcq_pkg::CW-1:0] + o_copy_src_end[gcq_pkg::CW-1:0]
           - o_copy_src[gcq_pkg::CW-1:0];
      unique case (state)
         gcq_pkg::ST_IDLE: begin
            if (q0_v) begin
               next_state = gcq_pkg::ST_DISP;
            end
         end
         gcq_pkg::ST_DISP: begin
            next_step = gcq_pkg::STEP0;
            next_state = gcq_pkg::ST_FETCH;
            next_cnt = i_cmd_param;
            next_colour = i_poly_colour;
            if (q0_code == gcq_pkg::CMD_NOP) begin
               next_state = gcq_pkg::ST_NO_OPERATION_CMD;
            end else if (q0_code != gcq_pkg::CMD_COPY && q0_code != gcq_pkg::CMD_STORE &&
                         q0_code != gcq_pkg::CMD_LOAD && q0_code != gcq_pkg::CMD_POLY) begin
               next_state = gcq_pkg::ST_NO_OPERATION_CMD;   // codes outside this block retire at once
            end
         end
         gcq_pkg::ST_FETCH: begin
            if (take) begin
               unique case (q0_code)
                  gcq_pkg::CMD_COPY: begin
                     next_step = step + gcq_pkg::STEP1;
                     if (step == gcq_pkg::STEP0) begin
                        next_copy_src = i_inq_data;
                     end else if (step == gcq_pkg::STEP1) begin
                        next_copy_src_end = i_inq_data & ~gcq_pkg::LAYER_MASK;
                     end else begin
                        next_copy_tgt = i_inq_data;
                        next_copy_tgt_end = {2'h0, ex, 2'h0, ey};
                        next_copy_req = 1'b1;
                        next_step = gcq_pkg::STEP0;
                        next_state = gcq_pkg::ST_COPY;
                        err_set = depth_of(lay_of(o_copy_src), i_layer_depth) !=
                                  depth_of(lay_of(i_inq_data), i_layer_depth);
                     end
                  end
                  gcq_pkg::CMD_STORE: begin
                     if (step == gcq_pkg::STEP0) begin
                        next_mem_addr = i_inq_data[gcq_pkg::MEM_AW-1:0];
                        next_step = gcq_pkg::STEP1;
                     end else begin
                        next_mem_wdata = i_inq_data;
                        next_mem_req = 1'b1;
                        next_mem_we = 1'b1;
                        next_state = gcq_pkg::ST_MEMW;
                     end
                  end
                  gcq_pkg::CMD_LOAD: begin
                     next_mem_addr = i_inq_data[gcq_pkg::MEM_AW-1:0];
                     if (cnt == 16'h0000) begin
                        done = 1'b1;
                     end else begin
                        next_mem_req = 1'b1;
                        next_mem_we = 1'b0;
                        next_state = gcq_pkg::ST_MEMR;
                     end
                  end
                  default: begin
                     if (step == gcq_pkg::STEP0) begin
                        next_pt_a = i_inq_data & ~gcq_pkg::LAYER_MASK;
                        next_step = gcq_pkg::STEP1;
                     end else begin
                        next_line_start = pt_a;
                        next_line_end = i_inq_data & ~gcq_pkg::LAYER_MASK;
                        next_pt_a = i_inq_data & ~gcq_pkg::LAYER_MASK;
                        // layer may change per next point
                        next_line_layer = i_use_layer ? i_target_layer : lay_of(i_inq_data);
                        next_line_colour = colour & cmask(depth_of(next_line_layer,
                                                                   i_layer_depth));
                        next_line_req = 1'b1;
                        next_state = gcq_pkg::ST_LINE;
                     end
                  end
               endcase
            end else if (q1_v && !i_inq_valid && q0_code != gcq_pkg::CMD_LOAD &&
                         (q0_code != gcq_pkg::CMD_COPY || step == gcq_pkg::STEP0)) begin
               // open command ends once input runs dry and a successor waits
               done = 1'b1;
            end
         end
         gcq_pkg::ST_MEMW: begin
            if (i_mem_ack) begin
               next_mem_req = 1'b0;
               next_mem_addr = o_mem_addr + gcq_pkg::ADDR_STEP;
               next_state = gcq_pkg::ST_FETCH;
            end
         end
         gcq_pkg::ST_MEMR: begin
            if (i_mem_ack) begin
               next_mem_req = 1'b0;
               next_outq_data = i_mem_rdata;
               next_outq_valid = 1'b1;
               next_state = gcq_pkg::ST_PUSH;
            end
         end
         gcq_pkg::ST_PUSH: begin
            if (i_outq_ready) begin
               next_outq_valid = 1'b0;
               next_cnt = cnt - 16'h0001;
               if (cnt == 16'h0001) begin
                  done = 1'b1;
               end else begin
                  next_mem_addr = o_mem_addr + gcq_pkg::ADDR_STEP;
                  next_mem_req = 1'b1;
                  next_state = gcq_pkg::ST_MEMR;
               end
            end
         end
         gcq_pkg::ST_COPY: begin
            if (i_copy_ack) begin
               next_copy_req = 1'b0;
               next_state = gcq_pkg::ST_FETCH;
            end
         end
         gcq_pkg::ST_LINE: begin
            if (i_line_ack) begin
               next_line_req = 1'b0;
               next_state = gcq_pkg::ST_FETCH;
            end
         end
         gcq_pkg::ST_NO_OPERATION_CMD: begin
            done = 1'b1;
         end
         default: begin
            next_state = gcq_pkg::ST_IDLE;
         end
      endcase
      // running entry retires, buffered one moves up
      if (done) begin
         next_state = gcq_pkg::ST_IDLE;
         next_q0_v = q1_v;
         next_q0_code = q1_code;
         next_q1_v = 1'b0;
      end
      if (i_cmd_wr && o_cmd_wen) begin
         if (!next_q0_v) begin
            next_q0_v = 1'b1;
            next_q0_code = i_cmd_code;
         end else begin
            next_q1_v = 1'b1;
            next_q1_code = i_cmd_code;
         end
      end
      next_err = err_set || (o_depth_err && !i_err_clr);
      // enable follows the free buffer entry
      next_cwen = !next_q1_v;
      next_inq_ready = (next_state == gcq_pkg::ST_FETCH) && !take;
      // software reset returns the controller to idle
      if (i_sw_reset) begin
         next_state = gcq_pkg::ST_IDLE;
         next_q0_v = 1'b0;
         next_q1_v = 1'b0;
         next_cwen = 1'b1;
         next_inq_ready = 1'b0;
         next_outq_valid = 1'b0;
         next_mem_req = 1'b0;
         next_copy_req = 1'b0;
         next_line_req = 1'b0;
         next_err = 1'b0;
      end
   end

   // state registers; trades one idle cycle per word in fetch for registered ready
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state <= gcq_pkg::ST_IDLE;
         q0_v <= 1'b0;
         q1_v <= 1'b0;
         q0_code <= gcq_pkg::RST_CODE;
         q1_code <= gcq_pkg::RST_CODE;
         step <= gcq_pkg::STEP0;
         cnt <= 16'h0000;
         colour <= 24'h000000;
         pt_a <= gcq_pkg::RST_WORD;
         o_cmd_wen <= 1'b1;
         o_inq_ready <= 1'b0;
         o_outq_valid <= 1'b0;
         o_outq_data <= gcq_pkg::RST_WORD;
         o_mem_req <= 1'b0;
         o_mem_we <= 1'b0;
         o_mem_addr <= 24'h000000;
         o_mem_wdata <= gcq_pkg::RST_WORD;
         o_copy_req <= 1'b0;
         o_copy_src <= gcq_pkg::RST_WORD;
         o_copy_src_end <= gcq_pkg::RST_WORD;
         o_copy_tgt <= gcq_pkg::RST_WORD;
         o_copy_tgt_end <= gcq_pkg::RST_WORD;
         o_line_req <= 1'b0;
         o_line_start <= gcq_pkg::RST_WORD;
         o_line_end <= gcq_pkg::RST_WORD;
         o_line_layer <= 4'h0;
         o_line_colour <= 24'h000000;
         o_depth_err <= 1'b0;
         o_copy_busy <= 1'b0;
         o_phys_busy <= 1'b0;
         o_draw_busy <= 1'b0;
         o_dreq_in <= 1'b0;
         o_dreq_out <= 1'b0;
      end else begin
         state <= next_state;
         q0_v <= next_q0_v;
         q1_v <= next_q1_v;
         q0_code <= next_q0_code;
         q1_code <= next_q1_code;
         step <= next_step;
         cnt <= next_cnt;
         colour <= next_colour;
         pt_a <= next_pt_a;
         o_cmd_wen <= next_cwen;
         o_inq_ready <= next_inq_ready;
         o_outq_valid <= next_outq_valid;
         o_outq_data <= next_outq_data;
         o_mem_req <= next_mem_req;
         o_mem_we <= next_mem_we;
         o_mem_addr <= next_mem_addr;
         o_mem_wdata <= next_mem_wdata;
         o_copy_req <= next_copy_req;
         o_copy_src <= next_copy_src;
         o_copy_src_end <= next_copy_src_end;
         o_copy_tgt <= next_copy_tgt;
         o_copy_tgt_end <= next_copy_tgt_end;
         o_line_req <= next_line_req;
         o_line_start <= next_line_start;
         o_line_end <= next_line_end;
         o_line_layer <= next_line_layer;
         o_line_colour <= next_line_colour;
         o_depth_err <= next_err;
         o_copy_busy <= next_q0_v && next_q0_code == gcq_pkg::CMD_COPY;
         o_phys_busy <= next_q0_v && (next_q0_code == gcq_pkg::CMD_STORE ||
                                      next_q0_code == gcq_pkg::CMD_LOAD);
         o_draw_busy <= next_q0_v && next_q0_code == gcq_pkg::CMD_POLY;
         // DMA requests track the queue handshakes
         o_dreq_in <= next_inq_ready;
         o_dreq_out <= next_outq_valid;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b || i_sw_reset);

   sequence s_read_done;
      state == gcq_pkg::ST_MEMR && i_mem_ack ##1 o_outq_valid;
   endsequence
   property p_cwen;
      o_cmd_wen != q1_v;
   endproperty
   a_cwen: assert property (p_cwen) else $error("write enable disagrees with queue");
   property p_no_operation_cmd;
      state == gcq_pkg::ST_NO_OPERATION_CMD |=> state == gcq_pkg::ST_IDLE && (q0_v || !$past(q1_v));
   endproperty
   a_no_operation_cmd: assert property (p_no_operation_cmd) else $error("no-op took more than one cycle");
   property p_err;
      state == gcq_pkg::ST_FETCH && take && q0_code == gcq_pkg::CMD_COPY &&
      step == gcq_pkg::STEP2 && err_set |=> o_depth_err;
   endproperty
   a_err: assert property (p_err) else $error("depth mismatch not flagged");
   property p_inc;
      state == gcq_pkg::ST_MEMW && i_mem_ack |=>
      o_mem_addr == $past(o_mem_addr) + gcq_pkg::ADDR_STEP;
   endproperty
   a_inc: assert property (p_inc) else $error("store address not advanced");
   property p_read;
      s_read_done |-> o_outq_data == $past(i_mem_rdata);
   endproperty
   a_read: assert property (p_read) else $error("loaded word lost");
   property p_last;
      state == gcq_pkg::ST_PUSH && i_outq_ready && cnt == 16'h0001 |=> state == gcq_pkg::ST_IDLE;
   endproperty
   a_last: assert property (p_last) else $error("load did not stop at count");
   property p_col;
      o_line_req |-> (o_line_colour & ~cmask(depth_of(o_line_layer, i_layer_depth))) == 24'h0;
   endproperty
   a_col: assert property (p_col) else $error("colour exceeds layer depth");
   property p_chain;
      state == gcq_pkg::ST_LINE && i_line_ack |=> pt_a == $past(o_line_end) ##1
      (state == gcq_pkg::ST_FETCH || state == gcq_pkg::ST_IDLE || step == gcq_pkg::STEP1);
   endproperty
   a_chain: assert property (p_chain) else $error("polyline not chained");
   property p_endlay;
      o_copy_req |-> (o_copy_src_end & gcq_pkg::LAYER_MASK) == 32'h0;
   endproperty
   a_endlay: assert property (p_endlay) else $error("source end layer kept");
endmodule : gcq_ctrl
`default_nettype wire

// >>> logic/unused_placeholder_removed.sv
// intentionally empty file
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> test/gcq_far_model.sv
// far-side model: memory, copy unit and drawing engine acknowledges
`timescale 1ns/1ps
`default_nettype none
module gcq_far_model (
   input  wire logic        i_clk,       // system clock
   input  wire logic        i_rst_b,     // async reset, active low
   input  wire logic        i_mem_req,   // memory request
   input  wire logic [23:0] i_mem_addr,  // byte address
   input  wire logic        i_copy_req,  // copy area request
   input  wire logic        i_line_req,  // line request
   output logic             o_mem_ack,   // memory done pulse
   output logic [31:0]      o_mem_rdata, // read data, scrambled off ack
   output logic             o_copy_ack,  // area taken pulse
   output logic             o_line_ack   // line taken pulse
);
   // one-cycle acks; data is inverted outside the ack cycle so stale reads show
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_mem_ack   <= 1'h0;
         o_mem_rdata <= 32'h0;
         o_copy_ack  <= 1'h0;
         o_line_ack  <= 1'h0;
      end else begin
         o_mem_ack   <= i_mem_req & ~o_mem_ack;
         o_mem_rdata <= (i_mem_req & ~o_mem_ack) ? {8'hA5, i_mem_addr} : ~{8'hA5, i_mem_addr};
         o_copy_ack  <= i_copy_req & ~o_copy_ack;
         o_line_ack  <= i_line_req & ~o_line_ack;
      end
   end
endmodule : gcq_far_model
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench for the command queue controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic i_clk = 1'h0, i_rst_b = 1'h0, i_sw_reset = 1'h0, i_cmd_wr = 1'h0, i_use_layer = 1'h0;
   logic i_err_clr = 1'h0, i_inq_valid = 1'h0, i_outq_ready = 1'h0;
   logic i_mem_ack, i_copy_ack, i_line_ack;
   logic [7:0] i_cmd_code = 8'h0;
   logic [15:0] i_cmd_param = 16'h0;
   logic [23:0] i_poly_colour = 24'h0, o_mem_addr, o_line_colour, a;
   logic [3:0] i_target_layer = 4'h0, o_line_layer;
   logic [47:0] i_layer_depth = 48'h0;
   logic [31:0] i_inq_data = 32'h0, i_mem_rdata, o_outq_data, o_mem_wdata, o_copy_src;
   logic [31:0] o_copy_src_end, o_copy_tgt, o_copy_tgt_end, o_line_start, o_line_end;
   logic o_cmd_wen, o_inq_ready, o_outq_valid, o_mem_req, o_mem_we, o_copy_req, o_line_req;
   logic o_depth_err, o_copy_busy, o_phys_busy, o_draw_busy, o_dreq_in, o_dreq_out;
   int err_total = 0;
   int n_tests = 0;
   int cyc = 0;
   gcq_ctrl i_dut (.*);
   gcq_far_model i_far (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_mem_req(o_mem_req),
      .i_mem_addr(o_mem_addr), .i_copy_req(o_copy_req), .i_line_req(o_line_req),
      .o_mem_ack(i_mem_ack), .o_mem_rdata(i_mem_rdata), .o_copy_ack(i_copy_ack),
      .o_line_ack(i_line_ack));
   initial forever #2.5 i_clk = ~i_clk;
   task conclude;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk
   task cmd(input logic [7:0] c);
      @(negedge i_clk);
      while (o_cmd_wen !== 1'h1) @(negedge i_clk);
      i_cmd_wr = 1'h1;
      i_cmd_code = c;
      @(negedge i_clk);
      i_cmd_wr = 1'h0;
   endtask : cmd
   // input word held until taken, then scrambled
   task push(input logic [31:0] w);
      @(negedge i_clk);
      i_inq_valid = 1'h1;
      i_inq_data = w;
      while (o_inq_ready !== 1'h1) @(negedge i_clk);
      chk(o_dreq_in, 1'h1);
      @(negedge i_clk);
      i_inq_valid = 1'h0;
      i_inq_data = ~w;
   endtask : push
   // hang guard, far above the fewer than a hundred cycles needed
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         conclude();
      end
   end
   initial begin
      repeat (2) @(posedge i_clk);
      @(negedge i_clk);
      i_rst_b = 1'h1;
      // load of two words with the drain stalled, so the queue fills
      i_cmd_param = 16'h0002; // load block of two words
      cmd(gcq_pkg::CMD_LOAD);
      push(32'h00000100);
      cmd(gcq_pkg::CMD_NOP);
      @(negedge i_clk);
      chk(o_cmd_wen, 1'h0);
      a = 24'h000100;
      for (int k = 0; k < 2; k++) begin
         while (o_outq_valid !== 1'h1) @(negedge i_clk);
         chk(o_outq_data, {8'hA5, a});
         chk(o_dreq_out, 1'h1);
         a = a + gcq_pkg::ADDR_STEP;
         i_outq_ready = 1'h1;
         @(negedge i_clk);
         i_outq_ready = 1'h0;
      end
      while (o_phys_busy === 1'h1) @(negedge i_clk);
      chk({o_mem_req, o_outq_valid}, 2'h0);
      repeat (4) @(negedge i_clk);
      chk(o_cmd_wen, 1'h1);
      // store: upper address bits beyond the fitted memory dropped
      cmd(gcq_pkg::CMD_STORE);
      push(32'hFF000200);
      a = 24'h000200;
      for (int k = 0; k < 2; k++) begin
         push(32'hC0DE0000 + k);
         while (o_mem_req !== 1'h1) @(negedge i_clk);
         chk(o_mem_addr, a);
         chk({o_mem_we, o_phys_busy}, 2'h3);
         chk(o_mem_wdata, 32'hC0DE0000 + k);
         a = a + gcq_pkg::ADDR_STEP;
      end
      cmd(gcq_pkg::CMD_NOP);
      // copy from an 8 bpp layer to a 16 bpp layer
      i_layer_depth[5:3] = gcq_pkg::BPP8;
      i_layer_depth[8:6] = gcq_pkg::BPP16;
      i_layer_depth[11:9] = gcq_pkg::BPP8;
      cmd(gcq_pkg::CMD_COPY);
      push({2'h0, 14'h000A, 2'h1, 14'h0014});
      push({2'h3, 14'h000F, 2'h3, 14'h001C});
      push({2'h0, 14'h0064, 2'h2, 14'h00C8});
      while (o_copy_req !== 1'h1) @(negedge i_clk);
      chk(o_copy_tgt, {2'h0, 14'h0064, 2'h2, 14'h00C8});
      chk(o_copy_src_end, {2'h0, 14'h000F, 2'h0, 14'h001C});
      chk(o_copy_tgt_end, {2'h0, 14'h0069, 2'h0, 14'h00D0});
      chk(o_depth_err, 1'h1);
      chk(o_copy_src, {2'h0, 14'h000A, 2'h1, 14'h0014});
      chk(o_copy_busy, 1'h1);
      cmd(gcq_pkg::CMD_NOP);
      i_err_clr = 1'h1;
      @(negedge i_clk);
      i_err_clr = 1'h0;
      @(negedge i_clk);
      chk(o_depth_err, 1'h0);
      // polyline over two layers; colour change mid-command must not show
      i_poly_colour = 24'hABCDEF;
      cmd(gcq_pkg::CMD_POLY);
      push({2'h3, 14'h0001, 2'h3, 14'h0002});
      push({2'h0, 14'h0005, 2'h3, 14'h0006});
      while (o_line_req !== 1'h1) @(negedge i_clk);
      chk(o_line_start, {2'h0, 14'h0001, 2'h0, 14'h0002});
      chk(o_line_end, {2'h0, 14'h0005, 2'h0, 14'h0006});
      chk(o_line_colour, 24'h0000EF);
      i_poly_colour = 24'h123456;
      push({2'h0, 14'h0009, 2'h1, 14'h0007});
      while (o_line_req !== 1'h1) @(negedge i_clk);
      chk(o_line_start, {2'h0, 14'h0005, 2'h0, 14'h0006});
      chk({o_line_layer, o_line_colour}, {4'h1, 24'h0000EF});
      cmd(gcq_pkg::CMD_NOP);
      repeat (4) @(negedge i_clk);
      chk({o_draw_busy, o_cmd_wen}, 2'h1);
      // software reset flushes a waiting load and its buffered successor
      cmd(gcq_pkg::CMD_LOAD);
      cmd(gcq_pkg::CMD_NOP);
      repeat (2) @(negedge i_clk);
      chk({o_cmd_wen, o_phys_busy}, 2'h1);
      i_sw_reset = 1'h1;
      @(negedge i_clk);
      i_sw_reset = 1'h0;
      chk({o_cmd_wen, o_phys_busy, o_inq_ready}, 3'h4);
      conclude();
   end
endmodule : testbench
`default_nettype wire
